// file: flash_ctrl_map.vh
// Purpose: register offsets, field positions and timing counts of the flash controller
// Assumes: APB with 32-bit data, one word per register
// Notes:   offsets are byte addresses
`ifndef FLASH_CTRL_MAP_VH
`define FLASH_CTRL_MAP_VH

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define OFS_OP_CONTROL   12'h000
`define OFS_UNLOCK_KEY   12'h004
`define OFS_TABLE_PAGE   12'h008
`define OFS_TABLE_ADDR   12'h00C
`define OFS_TABLE_LOW    12'h010
`define OFS_TABLE_HIGH   12'h014
`define OFS_STATUS       12'h018

// ---------------------------------------------------------------
// control fields
// ---------------------------------------------------------------
`define BIT_START        15
`define BIT_PERMIT       14
`define BIT_SEQ_ERR      13
`define BIT_ERASE_SEL    6
`define OPC_HI           3
`define OPC_LO           0
`define CTRL_RESET       16'h0000

// ---------------------------------------------------------------
// keys and operation codes
// ---------------------------------------------------------------
`define KEY_FIRST        8'h55
`define KEY_SECOND       8'hAA
`define OPC_BULK         4'hF
`define OPC_GENERAL      4'hD
`define OPC_SECURE       4'hC
`define OPC_WORD         4'h3
`define OPC_PAGE         4'h2
`define OPC_ROW          4'h1
`define OPC_CONFIG       4'h0

// ---------------------------------------------------------------
// geometry and timing
// ---------------------------------------------------------------
`define ROW_WORDS        64
`define ROW_IDX_W        6
`define PAGE_ROWS        8
`define ROW_BYTES        192
`define PAGE_BYTES       1536
`define ROW_TIME_CYC     11064
`define TABLE_WAIT_CYC   2

`endif

// file: flash_self_program_ctrl.v
// Purpose: run-time self-programming sequencer for on-chip program flash
// Assumes: APB slave on ref_clk; array port and oscillator tick come from same-clock logic
// Notes:   control register resets only from porRst_n; rst_n covers the rest except the holding buffer, which has no reset

`include "flash_ctrl_map.vh"

module flash_self_program_ctrl (
  // clock and resets
  input  wire        ref_clk,
  input  wire        rst_n,
  input  wire        porRst_n,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output wire        pslverr,
  // oscillator tick, one pulse per RC cycle
  input  wire        rcTick,
  // processor stall
  output wire        cpuStall,
  // flash array port
  output reg  [23:0] arrayAddr,
  output reg  [3:0]  arrayOp,
  output reg         arrayErase,
  output reg         arrayStrobe,
  output reg  [23:0] arrayData,
  output reg  [5:0]  arrayIndex
);

  // ---------------------------------------------------------------
  // states, one-hot
  // ---------------------------------------------------------------
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_BUSY = 3'b010;
  localparam [2:0] ST_DONE = 3'b100;

  // ---------------------------------------------------------------
  // software view
  // ---------------------------------------------------------------
  // register map, one 32-bit word each, upper bits read zero:
  //   0x000 control: start, permit, error flag, erase select, code
  //   0x004 unlock key: write-only, reads zero
  //   0x008 table page: upper eight bits of the 24-bit target
  //   0x00C table address: lower sixteen bits, also sets fill index
  //   0x010 table low: low data word into the holding buffer
  //   0x014 table high: high data byte, then index and address step
  //   0x018 status: armed flag, busy flag, fill index
  // status layout, lowest bits first:
  //   fill index in the low six bits
  //   busy just above it, high from start until the done cycle ends
  //   armed above busy, high from a good key pair until the next start or any write to a register other than control
  // a row program runs as:
  //   1. set the page and address registers to the row base
  //   2. write low then high for each of the 64 words
  //   3. put the address back on the row base
  //   4. write the code with permit set and erase select clear
  //   5. write the two key bytes back to back
  //   6. write the control word again with the start bit set
  // an erase runs the same way without step 2 and with erase select set
  // while an operation runs every access waits, so a core that polls
  // the control register simply stalls until the start bit drops
  // the error flag is also writable, so software can clear it by hand
  // before a new attempt; a refused start always wins over that write
  // limitations:
  //   - the buffer is not cleared after a program; a second program
  //     without a reload writes the same words again
  //   - every operation takes the row time; page, bulk and segment
  //     erases are not timed separately
  //   - word and configuration programs send only buffer word zero
  //   - the array port has no ready; it must accept one word a cycle
  //   - codes that do nothing are refused like a missing unlock,
  //     which sets the error flag instead of silently idling
  //   - a plain reset drops the unlock and the table pointer but keeps
  //     the control word, so software must reread it after a warm start

  // ---------------------------------------------------------------
  // reset synchronisers
  // ---------------------------------------------------------------
  reg rstMeta_q, rstSync_q, porMeta_q, porSync_q;
  wire rstInt_n = rstSync_q;
  wire porInt_n = porSync_q;

  // release both resets through two flops each
  // assertion stays asynchronous so the array port drops at once,
  // release is synchronous so no flop sees a half-released reset
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta_q <= 1'b0;
      rstSync_q <= 1'b0;
    end else begin
      rstMeta_q <= 1'b1;
      rstSync_q <= rstMeta_q;
    end
  end

  always @(posedge ref_clk or negedge porRst_n) begin
    if (!porRst_n) begin
      porMeta_q <= 1'b0;
      porSync_q <= 1'b0;
    end else begin
      porMeta_q <= 1'b1;
      porSync_q <= porMeta_q;
    end
  end

  // ---------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------
  // true when the code names a real operation for the given direction
  function opValid;
    input       erase;
    input [3:0] code;
    begin
      if (erase)
        opValid = (code == `OPC_BULK) || (code == `OPC_GENERAL) ||
                  (code == `OPC_SECURE) || (code == `OPC_PAGE) ||
                  (code == `OPC_CONFIG);
      else
        opValid = (code == `OPC_WORD) || (code == `OPC_ROW) ||
                  (code == `OPC_CONFIG);
    end
  endfunction

  // oscillator ticks an operation takes
  // kept as a function so separate erase times can be added later
  // without touching the sequencer
  function [13:0] opTicks;
    input       erase;
    input [3:0] code;
    begin
      if (!erase && code == `OPC_ROW)
        opTicks = 14'd`ROW_TIME_CYC;
      else
        opTicks = 14'd`ROW_TIME_CYC;
    end
  endfunction

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  reg        start_q, permit_q, seqErr_q, eraseSel_q;
  reg  [3:0] opCode_q;
  reg        keyHalf_q, armed_q;
  reg  [7:0] tablePage_q;
  reg [15:0] tableAddr_q;
  reg  [2:0] state_q;
  reg [13:0] tickCnt_q;
  reg  [1:0] tblWait_q;
  reg [23:0] holdBuf_q [0:`ROW_WORDS-1];
  reg [`ROW_IDX_W-1:0] fillIdx_q;
  reg        feedDone_q;

  // last buffer index of a row
  localparam [6:0] LAST_IDX = 7'd`ROW_WORDS - 7'd1;

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------

  wire        access   = psel && penable;
  wire        wrAcc    = access && pwrite && pready;
  wire        hitCtrl  = (paddr == `OFS_OP_CONTROL);
  wire        hitKey   = (paddr == `OFS_UNLOCK_KEY);
  wire        hitPage  = (paddr == `OFS_TABLE_PAGE);
  wire        hitAddr  = (paddr == `OFS_TABLE_ADDR);
  wire        hitLow   = (paddr == `OFS_TABLE_LOW);
  wire        hitHigh  = (paddr == `OFS_TABLE_HIGH);
  wire        hitStat  = (paddr == `OFS_STATUS);
  wire        mapped   = hitCtrl | hitKey | hitPage | hitAddr | hitLow | hitHigh | hitStat;
  wire        isTable  = hitLow | hitHigh;
  wire        busy     = !state_q[0];
  wire        startReq = wrAcc && hitCtrl && pwdata[`BIT_START] && !start_q;
  wire        startOk  = startReq && armed_q && permit_q && pwdata[`BIT_PERMIT] &&
                         opValid(pwdata[`BIT_ERASE_SEL], pwdata[`OPC_HI:`OPC_LO]);
  wire        opDone   = state_q[1] && rcTick && (tickCnt_q == 14'd1);
  wire [23:0] target   = {tablePage_q, tableAddr_q};

  // table writes wait two cycles; register writes stall while busy
  // holding pready low is what stalls the core, so no separate wait
  // request is needed on the processor side
  assign pready   = busy ? 1'b0 :
                    (isTable && pwrite) ? (tblWait_q == 2'd`TABLE_WAIT_CYC - 2'd1) : 1'b1;
  assign pslverr  = access && pready && !mapped;
  assign cpuStall = busy;

  // table write wait counter
  always @(posedge ref_clk or negedge rstInt_n) begin
    if (!rstInt_n)
      tblWait_q <= 2'd0;
    else if (access && pwrite && isTable && !pready)
      tblWait_q <= tblWait_q + 2'd1;
    else
      tblWait_q <= 2'd0;
  end

  // control fields, power-on reset only; frozen while an operation runs
  always @(posedge ref_clk or negedge porInt_n) begin
    if (!porInt_n) begin
      permit_q   <= 1'b0;
      eraseSel_q <= 1'b0;
      opCode_q   <= 4'h0;
    end else if (wrAcc && hitCtrl && !busy) begin
      permit_q   <= pwdata[`BIT_PERMIT];
      eraseSel_q <= pwdata[`BIT_ERASE_SEL];
      opCode_q   <= pwdata[`OPC_HI:`OPC_LO];
    end
  end

  // start bit and error flag; a refused start sets the flag even when
  // the same write tries to clear it, so an error is never lost
  always @(posedge ref_clk or negedge porInt_n) begin
    if (!porInt_n) begin
      start_q  <= 1'b0;
      seqErr_q <= 1'b0;
    end else begin
      if (startOk)
        start_q <= 1'b1;
      else if (opDone)
        start_q <= 1'b0;
      if (startReq && !startOk)
        seqErr_q <= 1'b1;
      else if (startOk)
        seqErr_q <= 1'b0;
      else if (wrAcc && hitCtrl && !busy)
        seqErr_q <= pwdata[`BIT_SEQ_ERR];
    end
  end

  // key sequence tracking
  // any write between the two key bytes breaks the pair, so a stray
  // store from an interrupt cannot half-unlock the array
  always @(posedge ref_clk or negedge rstInt_n) begin
    if (!rstInt_n) begin
      keyHalf_q <= 1'b0;
      armed_q   <= 1'b0;
    end else if (wrAcc && hitKey) begin
      keyHalf_q <= (pwdata[7:0] == `KEY_FIRST);
      armed_q   <= keyHalf_q && (pwdata[7:0] == `KEY_SECOND);
    end else if (wrAcc) begin
      keyHalf_q <= 1'b0;
      if (startReq || !hitCtrl)
        armed_q <= 1'b0;
    end
  end

  // table pointer and holding buffer fill
  always @(posedge ref_clk or negedge rstInt_n) begin
    if (!rstInt_n) begin
      tablePage_q <= 8'h00;
      tableAddr_q <= 16'h0000;
      fillIdx_q   <= {`ROW_IDX_W{1'b0}};
    end else if (wrAcc) begin
      if (hitPage)
        tablePage_q <= pwdata[7:0];
      if (hitAddr) begin
        tableAddr_q <= pwdata[15:0];
        fillIdx_q   <= pwdata[`ROW_IDX_W:1];
      end
      if (hitHigh) begin
        fillIdx_q   <= fillIdx_q + 1'b1;
        tableAddr_q <= tableAddr_q + 16'h0002;
      end
    end
  end

  // buffer storage, no reset needed
  // low and high halves land on separate writes, so each half has its
  // own enable; the index only steps on the high write
  always @(posedge ref_clk) begin
    if (wrAcc && hitLow)
      holdBuf_q[fillIdx_q][15:0] <= pwdata[15:0];
    if (wrAcc && hitHigh)
      holdBuf_q[fillIdx_q][23:16] <= pwdata[7:0];
  end

  // sequencer, timed from oscillator ticks
  // the row is streamed out in the first cycles of the operation and
  // the rest of the time only counts ticks; the done cycle lets the
  // start bit fall before the bus is released
  always @(posedge ref_clk or negedge rstInt_n) begin
    if (!rstInt_n) begin
      state_q     <= ST_IDLE;
      tickCnt_q   <= 14'd0;
      arrayAddr   <= 24'h000000;
      arrayOp     <= 4'h0;
      arrayErase  <= 1'b0;
      arrayStrobe <= 1'b0;
      arrayData   <= 24'h000000;
      arrayIndex  <= 6'd0;
      feedDone_q  <= 1'b1;
    end else begin
      arrayStrobe <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (startOk) begin
            state_q    <= ST_BUSY;
            tickCnt_q  <= opTicks(pwdata[`BIT_ERASE_SEL], pwdata[`OPC_HI:`OPC_LO]);
            arrayAddr  <= target;
            arrayOp    <= pwdata[`OPC_HI:`OPC_LO];
            arrayErase <= pwdata[`BIT_ERASE_SEL];
            arrayIndex <= 6'd0;
            feedDone_q <= pwdata[`BIT_ERASE_SEL]; // erases send no data
          end
        end
        ST_BUSY: begin
          if (rcTick)
            tickCnt_q <= tickCnt_q - 14'd1;
          // one buffer word a cycle; a row sends all 64, word ops one
          if (!feedDone_q) begin
            arrayStrobe <= 1'b1;
            arrayData   <= holdBuf_q[arrayIndex];
            arrayIndex  <= arrayIndex + 6'd1;
            feedDone_q  <= (arrayOp != `OPC_ROW) ||
                           ({1'b0, arrayIndex} == LAST_IDX);
          end
          if (opDone)
            state_q <= ST_DONE;
        end
        ST_DONE: begin
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // read mux; key register and unmapped offsets read zero
  always @* begin
    prdata = 32'h00000000;
    case (paddr)
      `OFS_OP_CONTROL: begin
        prdata[15:0] = {start_q, permit_q, seqErr_q, 6'b000000, eraseSel_q, 2'b00, opCode_q};
      end
      `OFS_TABLE_PAGE: begin
        prdata[7:0] = tablePage_q;
      end
      `OFS_TABLE_ADDR: begin
        prdata[15:0] = tableAddr_q;
      end
      `OFS_STATUS: begin
        prdata[`ROW_IDX_W+1:0] = {armed_q, busy, fillIdx_q};
      end
      `OFS_UNLOCK_KEY: begin
        prdata = 32'h00000000;
      end
      default: begin
        prdata = 32'h00000000;
      end
    endcase
  end

endmodule // flash_self_program_ctrl

// file: flash_ctrl_props.sv
// Purpose: port-level assertions for the flash self-program sequencer
// Assumes: single ref_clk domain; both resets active low
// Notes:   bound to the top module at the foot of this file
module flash_ctrl_props (
  // clock and resets
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic        porRst_n,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  // timing and stall
  input wire logic        rcTick,
  input wire logic        cpuStall
);
  logic [15:0] tickCnt_q;
  wire         acc = psel && penable;
  wire         rdOk = acc && pready && !pwrite;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n || !porRst_n);
  // ticks seen during one busy span, cleared while idle
  always_ff @(posedge ref_clk) begin
    tickCnt_q <= cpuStall ? tickCnt_q + {15'h0, rcTick} : 16'h0;
  end
  a_stall_blocks_ready: assert property (acc && cpuStall |-> !pready)
    else $error("access answered while stalled");
  a_key_reads_zero: assert property (rdOk && paddr == 12'h004 |-> prdata == 32'h0)
    else $error("key register read not zero");
  a_ctrl_zero_bits: assert property (rdOk && paddr == 12'h000 |->
    prdata[31:16] == 16'h0 && prdata[12:7] == 6'h0 && prdata[5:4] == 2'h0)
    else $error("unimplemented control bits set");
  a_start_idle_clear: assert property (rdOk && paddr == 12'h000 |-> !prdata[15])
    else $error("start bit seen while idle");
  a_table_two_cycles: assert property ($rose(penable) && psel && pwrite && !cpuStall &&
    (paddr == 12'h010 || paddr == 12'h014) |-> !pready ##1 pready)
    else $error("table write not two cycles");
  a_reg_ready_now: assert property (acc && !cpuStall &&
    paddr inside {12'h000, 12'h004, 12'h008, 12'h00C, 12'h018} |-> pready)
    else $error("register access not answered at once");
  a_unmapped_err: assert property (acc && pready && paddr > 12'h018 |-> pslverr)
    else $error("unmapped access without error");
  a_stall_needs_start: assert property ($rose(cpuStall) |->
    $past(acc && pwrite && paddr == 12'h000 && pwdata[15]))
    else $error("stall without start write");
  a_row_time_ticks: assert property ($fell(cpuStall) |->
    tickCnt_q inside {[16'd11064:16'd11065]})
    else $error("operation length wrong");
endmodule // flash_ctrl_props

bind flash_self_program_ctrl flash_ctrl_props u_props (
  .ref_clk(ref_clk), .rst_n(rst_n), .porRst_n(porRst_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pready(pready), .prdata(prdata), .pslverr(pslverr), .rcTick(rcTick),
  .cpuStall(cpuStall));

// file: rc_osc_model.sv
// Purpose: internal RC oscillator tick source and array strobe counter
// Assumes: tick is a same-clock pulse, DIV ref_clk cycles apart
// Notes:   DIV of 1 keeps long operations inside the run budget
module rc_osc_model #(
  parameter int DIV = 1
) (
  input  wire logic ref_clk,
  input  wire logic arrayStrobe,
  output logic      rcTick,
  output int        strobeCount
);
  int divCnt_q = 0;
  initial rcTick = 1'b0;
  initial strobeCount = 0;
  // free-running: the RC source never pauses between operations
  always @(posedge ref_clk) begin
    divCnt_q    <= (divCnt_q == DIV - 1) ? 0 : divCnt_q + 1;
    rcTick      <= (divCnt_q == DIV - 1);
    strobeCount <= strobeCount + int'(arrayStrobe);
  end
endmodule // rc_osc_model

// file: flash_self_program_ctrl_tb.sv
// Purpose: self-checking bench for the flash self-program sequencer
// Assumes: APB master here; oscillator model on the far side
// Notes:   every operation takes 11064 ticks, so few are run
`define CHK(nm, ex, got) begin numChecks++; if ((got) !== (ex)) begin errors++; \
  $display("unexpected %s exp %h got %h", nm, ex, got); end end
module flash_self_program_ctrl_tb;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {logic wr; logic [11:0] a; logic [31:0] d; logic e;} row_t;
  logic        ref_clk, rst_n, porRst_n, psel, penable, pwrite, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, rd;
  wire  [31:0] prdata;
  wire  [23:0] arrayAddr, arrayData;
  wire  [3:0]  arrayOp;
  wire  [5:0]  arrayIndex;
  wire         pready, pslverr, rcTick, cpuStall, arrayErase, arrayStrobe;
  int          errors = 0, numChecks = 0, strobes, s0;
  row_t rows[10] = '{'{0, 12'h000, 0, 0}, '{0, 12'h004, 0, 0}, '{1, 12'h004, 32'h1234, 0},
    '{0, 12'h004, 0, 0}, '{1, 12'h000, 32'hFFFF, 0}, '{0, 12'h000, 32'h604F, 0},
    '{1, 12'h000, 32'h4001, 0}, '{1, 12'h000, 32'hC001, 0}, '{0, 12'h000, 32'h6001, 0},
    '{0, 12'h020, 0, 1}};
  logic [15:0] ops[4] = '{16'hC042, 16'hC001, 16'hC04F, 16'hC003};
  flash_self_program_ctrl uut (.ref_clk(ref_clk), .rst_n(rst_n), .porRst_n(porRst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .rcTick(rcTick),
    .cpuStall(cpuStall), .arrayAddr(arrayAddr), .arrayOp(arrayOp), .arrayErase(arrayErase),
    .arrayStrobe(arrayStrobe), .arrayData(arrayData), .arrayIndex(arrayIndex));
  rc_osc_model osc (.ref_clk(ref_clk), .arrayStrobe(arrayStrobe), .rcTick(rcTick),
    .strobeCount(strobes));
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // ------------------------------------------------------------
  // bus tasks
  // ------------------------------------------------------------
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    // request stands until pready is seen high at a rising edge
    do
      @(posedge ref_clk);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  // unlock, start, check the launch, then wait out the stall
  task automatic op(input logic [15:0] ctl);
    apb(1'b1, 12'h004, 32'h55);
    apb(1'b1, 12'h004, 32'hAA);
    apb(1'b1, 12'h000, {16'h0, ctl});
    repeat (2) @(negedge ref_clk);
    `CHK("stall", 1'b1, cpuStall)
    `CHK("op code", ctl[3:0], arrayOp)
    `CHK("erase sel", ctl[6], arrayErase)
    `CHK("target", 24'h010000, arrayAddr)
    apb(1'b0, 12'h000, 32'h0);
    `CHK("done ctrl", {16'h0, ctl & 16'h7FFF}, rd)
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", numChecks, errors);
    if (errors == 0 && numChecks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------
  initial begin
    {rst_n, porRst_n, psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (4) @(posedge ref_clk);
    rst_n    <= 1'b1;
    porRst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    foreach (rows[i]) begin
      apb(rows[i].wr, rows[i].a, rows[i].d);
      if (!rows[i].wr && !rows[i].e) `CHK("reg read", rows[i].d, rd)
      `CHK("slave error", rows[i].e, er)
    end
    // fill one whole row, then run a page erase, a row program, a bulk erase and a word program
    apb(1'b1, 12'h008, 32'h01);
    apb(1'b1, 12'h00C, 32'h0);
    s0 = strobes;
    for (int i = 0; i < 64; i++) begin
      apb(1'b1, 12'h010, 32'h1000 + i);
      apb(1'b1, 12'h014, i);
    end
    apb(1'b1, 12'h00C, 32'h0);
    foreach (ops[i]) begin
      op(ops[i]);
      if (i == 1) `CHK("row words", 64, strobes - s0)
      if (i == 1) `CHK("last word", 24'h3F103F, arrayData)
      if (i == 1) `CHK("index wrap", 6'd0, arrayIndex)
    end
    // a stray key write drops the unlock
    apb(1'b1, 12'h004, 32'h55);
    apb(1'b1, 12'h004, 32'hAA);
    apb(1'b1, 12'h004, 32'h00);
    apb(1'b1, 12'h000, 32'hC042);
    apb(1'b0, 12'h000, 32'h0);
    `CHK("disarmed", 32'h6042, rd)
    // permit bit clear blocks a keyed start
    apb(1'b1, 12'h000, 32'h0042);
    apb(1'b1, 12'h004, 32'h55);
    apb(1'b1, 12'h004, 32'hAA);
    apb(1'b1, 12'h000, 32'h8042);
    apb(1'b0, 12'h000, 32'h0);
    `CHK("no permit", 32'h2042, rd)
    // plain reset keeps control bits; power-on reset clears them
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    apb(1'b0, 12'h000, 32'h0);
    `CHK("warm reset", 32'h2042, rd)
    porRst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    porRst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    apb(1'b0, 12'h000, 32'h0);
    `CHK("por reset", 32'h0, rd)
    complete_run();
  end
  // hang guard: four operations plus register traffic fit well inside
  initial begin
    repeat (90000) @(posedge ref_clk);
    errors++;
    complete_run();
  end
endmodule // flash_self_program_ctrl_tb
